// [logic/zqc_pkg.sv]
package zqc_pkg;

  // ==========================================================
  // clock and timing
  // ==========================================================
  localparam int CLK_PERIOD_NS          = 100;
  localparam int INIT_CAL_PERIOD_NS     = 102400;
  localparam int OPER_CAL_PERIOD_NS     = 51200;
  // both times round down to whole cycles
  localparam int INIT_CAL_CYCLES        = INIT_CAL_PERIOD_NS / CLK_PERIOD_NS;
  localparam int OPER_CAL_CYCLES        = OPER_CAL_PERIOD_NS / CLK_PERIOD_NS;
  localparam int CNT_W                  = 11;
  localparam logic [CNT_W-1:0] INIT_CNT = CNT_W'(INIT_CAL_CYCLES);
  localparam logic [CNT_W-1:0] OPER_CNT = CNT_W'(OPER_CAL_CYCLES);
  // width of the counter that spaces comparator driven code steps 16 cycles apart
  localparam int STEP_W                 = 4;

  // ==========================================================
  // field widths and reset values
  // ==========================================================
  localparam int CODE_W                 = 5;
  localparam logic [CODE_W-1:0] CODE_RST = 5'h10;
  localparam logic [CODE_W-1:0] CODE_MAX = 5'h1f;
  localparam int RTT_W                  = 3;
  localparam logic [RTT_W-1:0] RTT_OFF  = 3'h0;
  localparam logic [RTT_W-1:0] NOM_DIS  = 3'h0;

  // synchroniser bit positions
  localparam int SYN_W                  = 6;
  localparam int SYN_LCK                = 0;
  localparam int SYN_CKE                = 1;
  localparam int SYN_LONG               = 2;
  localparam int SYN_SHORT              = 3;
  localparam int SYN_ODT                = 4;
  localparam int SYN_CMP                = 5;

  // calibration sequencer
  typedef enum logic [2:0] {
    ZQC_IDLE = 3'h1,
    ZQC_CAL  = 3'h2,
    ZQC_XFER = 3'h4
  } zqc_state_t;

endpackage

// [logic/zqc_sync.sv]
`timescale 1ns/1ps
module zqc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // ==========================================================
  // two flops per bit, first flop feeds only the second
  // ==========================================================
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (rst) begin
        meta_q[i]   <= 1'b0;
        sync_out[i] <= 1'b0;
      end else begin
        meta_q[i]   <= async_in[i];
        sync_out[i] <= meta_q[i];
      end
    end
  end

endmodule

// [logic/zqc_top.sv]
`timescale 1ns/1ps
module zqc_top (
  input  wire logic                       CLOCK,
  input  wire logic                       RST,
  input  wire logic                       LINK_CK,
  input  wire logic                       CKE,
  input  wire logic                       LONG_IMPEDANCE_CALIBRATION_CMD,
  input  wire logic                       SHORT_IMPEDANCE_CALIBRATION_CMD,
  input  wire logic                       ODT,
  input  wire logic                       CAL_CMP_HIGH,
  input  wire logic                       SELF_REFRESH,
  input  wire logic [zqc_pkg::RTT_W-1:0]  PARKED_TERMINATION_VALUE,
  input  wire logic [zqc_pkg::RTT_W-1:0]  NOMINAL_TERMINATION_VALUE,
  input  wire logic                       TDQS_ENABLE,
  output logic                            CAL_BUSY,
  output logic                            CAL_FIRST_DONE,
  output logic                            CAL_DONE_PULSE,
  output logic [zqc_pkg::CODE_W-1:0]      DRIVER_IMP_CODE,
  output logic [zqc_pkg::CODE_W-1:0]      TERM_IMP_CODE,
  output logic [zqc_pkg::RTT_W-1:0]       DQ_TERM_VALUE,
  output logic [zqc_pkg::RTT_W-1:0]       TDQS_TERM_VALUE
);
  import zqc_pkg::*;

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  logic [SYN_W-1:0] pins_raw;
  logic [SYN_W-1:0] pins_s;

  assign pins_raw[SYN_LCK]   = LINK_CK;
  assign pins_raw[SYN_CKE]   = CKE;
  assign pins_raw[SYN_LONG]  = LONG_IMPEDANCE_CALIBRATION_CMD;
  assign pins_raw[SYN_SHORT] = SHORT_IMPEDANCE_CALIBRATION_CMD;
  assign pins_raw[SYN_ODT]   = ODT;
  assign pins_raw[SYN_CMP]   = CAL_CMP_HIGH;

  zqc_sync #(
    .W        (SYN_W)
  ) u_sync (
    .clk      (CLOCK),
    .rst      (RST),
    .async_in (pins_raw),
    .sync_out (pins_s)
  );

  // ==========================================================
  // link clock edge detection and command capture
  // ==========================================================
  logic lck_prev_q;
  logic lck_rise;
  logic long_cmd;
  logic short_cmd;

  // link clock, clock enable and command pins pass the same two flops, so they stay aligned to the edge
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      lck_prev_q <= 1'b0;
    end else begin
      lck_prev_q <= pins_s[SYN_LCK];
    end
  end

  assign lck_rise  = pins_s[SYN_LCK] & ~lck_prev_q;
  // commands only count on a link edge with clock enable high
  assign long_cmd  = lck_rise & pins_s[SYN_CKE] & pins_s[SYN_LONG];
  // short form is decoded only to be dropped
  assign short_cmd = lck_rise & pins_s[SYN_CKE] & pins_s[SYN_SHORT];

  // ==========================================================
  // calibration sequencer
  // ==========================================================
  zqc_state_t       state_q;
  zqc_state_t       state_d;
  logic [CNT_W-1:0] cnt_q;
  logic             first_done_q;
  logic             cnt_end;

  assign cnt_end = (cnt_q == '0);

  // next state; a short command never leaves idle
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ZQC_IDLE: begin
        if (long_cmd) begin
          state_d = ZQC_CAL;
        end
      end
      ZQC_CAL: begin
        if (cnt_end) begin
          state_d = ZQC_XFER;
        end
      end
      ZQC_XFER: begin
        state_d = ZQC_IDLE;
      end
      default: begin
        state_d = ZQC_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_q <= ZQC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // period counter: first run after reset gets the long budget
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      cnt_q <= '0;
    end else if (state_q == ZQC_IDLE && long_cmd) begin
      cnt_q <= first_done_q ? OPER_CNT - 1'b1 : INIT_CNT - 1'b1;
    end else if (state_q == ZQC_CAL && !cnt_end) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // remembers that the initial calibration has completed
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      first_done_q <= 1'b0;
    end else if (state_q == ZQC_XFER) begin
      first_done_q <= 1'b1;
    end
  end

  // ==========================================================
  // calibration engine: comparator steers a tracking code
  // ==========================================================
  logic [CODE_W-1:0] eng_code_q;
  logic [STEP_W-1:0] step_q;
  logic              step_now;

  assign step_now = (step_q == '0);

  // comparator needs time to settle after each code change
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      step_q <= '0;
    end else if (state_q != ZQC_CAL) begin
      step_q <= '1;
    end else begin
      step_q <= step_q - 1'b1;
    end
  end

  // saturating up/down track; a full-range sweep needs 31 of the 32 steps in the operating period
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      eng_code_q <= CODE_RST;
    end else if (state_q == ZQC_CAL && step_now) begin
      if (pins_s[SYN_CMP] && eng_code_q != '0) begin
        eng_code_q <= eng_code_q - 1'b1;
      end else if (!pins_s[SYN_CMP] && eng_code_q != CODE_MAX) begin
        eng_code_q <= eng_code_q + 1'b1;
      end
    end
  end

  // ==========================================================
  // transfer to the I/O, only at the end of a long calibration
  // ==========================================================
  // self-refresh exit has no path in here, so no silent recalibration
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      DRIVER_IMP_CODE <= CODE_RST;
      TERM_IMP_CODE   <= CODE_RST;
    end else if (state_q == ZQC_XFER) begin
      DRIVER_IMP_CODE <= eng_code_q;
      TERM_IMP_CODE   <= eng_code_q;
    end
  end

  // status flags
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      CAL_BUSY       <= 1'b0;
      CAL_FIRST_DONE <= 1'b0;
      CAL_DONE_PULSE <= 1'b0;
    end else begin
      CAL_BUSY       <= (state_d != ZQC_IDLE);
      CAL_FIRST_DONE <= first_done_q | (state_q == ZQC_XFER);
      CAL_DONE_PULSE <= (state_q == ZQC_XFER);
    end
  end

  // ==========================================================
  // termination control
  // ==========================================================
  logic             odt_honoured;
  logic             term_on;
  logic [RTT_W-1:0] dq_term_d;
  logic             unused_short;

  // the pin counts only outside self-refresh with nominal enabled
  assign odt_honoured = (NOMINAL_TERMINATION_VALUE != NOM_DIS) & ~SELF_REFRESH;
  // ignored pin leaves parked termination on; honoured pin gates it
  // next state is included so termination drops with busy, not a cycle late
  assign term_on      = ~SELF_REFRESH
                        & (state_q == ZQC_IDLE)
                        & (state_d == ZQC_IDLE)
                        & (~odt_honoured | pins_s[SYN_ODT]);
  // either the parked value or nothing; no nominal or dynamic value
  assign dq_term_d    = term_on ? PARKED_TERMINATION_VALUE : RTT_OFF;
  // short command has no effect on any code or value
  assign unused_short = short_cmd;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      DQ_TERM_VALUE   <= RTT_OFF;
      TDQS_TERM_VALUE <= RTT_OFF;
    end else begin
      DQ_TERM_VALUE   <= dq_term_d;
      TDQS_TERM_VALUE <= TDQS_ENABLE ? dq_term_d : RTT_OFF;
    end
  end

endmodule

// [tb/zqc_chk.sv]
`timescale 1ns/1ps
module zqc_chk
  import zqc_pkg::*;
(
  input wire logic       CLOCK,
  input wire logic       RST,
  input wire logic       LONG_IMPEDANCE_CALIBRATION_CMD,
  input wire logic       SELF_REFRESH,
  input wire logic [2:0] PARKED_TERMINATION_VALUE,
  input wire logic [2:0] NOMINAL_TERMINATION_VALUE,
  input wire logic       TDQS_ENABLE,
  input wire logic       CAL_BUSY,
  input wire logic       CAL_FIRST_DONE,
  input wire logic       CAL_DONE_PULSE,
  input wire logic [4:0] DRIVER_IMP_CODE,
  input wire logic [2:0] DQ_TERM_VALUE,
  input wire logic [2:0] TDQS_TERM_VALUE
);
  logic [11:0] busy_cnt_q;

  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);

  // ==========================================================
  // busy length counter
  // ==========================================================
  // periods stay below 4096, so twelve bits never wrap
  always_ff @(posedge CLOCK) begin
    if (RST || !CAL_BUSY) busy_cnt_q <= 12'h000;
    else busy_cnt_q <= busy_cnt_q + 12'h001;
  end

  sequence s_cal_end;
    $fell(CAL_BUSY) && CAL_DONE_PULSE;
  endsequence

  // ==========================================================
  // calibration
  // ==========================================================
  a_busy_len: assert property ($fell(CAL_BUSY) |-> busy_cnt_q == 12'($past(CAL_FIRST_DONE) ?
    OPER_CAL_CYCLES + 1 : INIT_CAL_CYCLES + 1)) else $error("calibration length wrong");
  a_done_pulse: assert property (CAL_DONE_PULSE |-> s_cal_end ##1 !CAL_DONE_PULSE)
    else $error("done pulse not tied to end of calibration");
  a_start_cause: assert property ($rose(CAL_BUSY) |-> $past(LONG_IMPEDANCE_CALIBRATION_CMD, 3))
    else $error("calibration started without long command");
  a_codes_hold: assert property (!CAL_DONE_PULSE && !$past(RST) |-> $stable(DRIVER_IMP_CODE))
    else $error("codes moved outside a transfer");

  // ==========================================================
  // termination
  // ==========================================================
  a_busy_term: assert property (CAL_BUSY |-> DQ_TERM_VALUE == RTT_OFF && TDQS_TERM_VALUE == RTT_OFF)
    else $error("termination on while calibrating");
  a_sr_off: assert property ($past(SELF_REFRESH) |-> DQ_TERM_VALUE == RTT_OFF)
    else $error("termination on in self-refresh");
  a_tdqs_off: assert property (!$past(TDQS_ENABLE) |-> TDQS_TERM_VALUE == RTT_OFF)
    else $error("strobe termination without enable");
  a_park_only: assert property (DQ_TERM_VALUE != RTT_OFF |->
    DQ_TERM_VALUE == $past(PARKED_TERMINATION_VALUE)) else $error("termination not parked value");
  a_nom_ignore: assert property (!CAL_BUSY && !$past(CAL_BUSY) && !CAL_DONE_PULSE && !$past(RST)
    && !$past(SELF_REFRESH) && $past(NOMINAL_TERMINATION_VALUE) == NOM_DIS
    |-> DQ_TERM_VALUE == $past(PARKED_TERMINATION_VALUE)) else $error("pin not ignored");
endmodule

bind zqc_top zqc_chk zqc_chk_inst (.*);

// [tb/zqc_ctrl_model.sv]
`timescale 1ns/1ps
module zqc_ctrl_model (
  input  wire logic CLOCK,
  input  wire logic SEND,
  input  wire logic KIND_LONG,
  input  wire logic CKE_EN,
  output logic      LINK_CK,
  output logic      LONG_IMPEDANCE_CALIBRATION_CMD,
  output logic      SHORT_IMPEDANCE_CALIBRATION_CMD,
  output logic      CKE
);
  // one link clock period per command; the clock stands low between frames
  // no data lines are driven here, so the data bus stays released throughout
  initial begin
    LINK_CK = 1'b0;
    LONG_IMPEDANCE_CALIBRATION_CMD = 1'b0;
    SHORT_IMPEDANCE_CALIBRATION_CMD = 1'b0;
    CKE = 1'b1;
    forever begin
      @(posedge CLOCK);
      if (SEND) begin
        CKE <= CKE_EN;
        LONG_IMPEDANCE_CALIBRATION_CMD <= KIND_LONG;
        SHORT_IMPEDANCE_CALIBRATION_CMD <= !KIND_LONG;
        // fixed 37 ns offset puts the link edge between system clock edges, at the same phase every time
        repeat (3) @(posedge CLOCK);
        #37 LINK_CK = 1'b1;
        #400 LINK_CK = 1'b0;
        repeat (4) @(posedge CLOCK);
        LONG_IMPEDANCE_CALIBRATION_CMD <= 1'b0;
        SHORT_IMPEDANCE_CALIBRATION_CMD <= 1'b0;
        CKE <= 1'b1;
      end
    end
  end
endmodule

// [tb/test_zqc_top.sv]
`timescale 1ns/1ps
module test_zqc_top;
  import zqc_pkg::*;
  logic CLOCK, RST, LINK_CK, CKE, ODT, CAL_CMP_HIGH, SELF_REFRESH, TDQS_ENABLE, SEND;
  logic KIND_LONG, CKE_EN, CAL_BUSY, CAL_FIRST_DONE, CAL_DONE_PULSE;
  logic LONG_IMPEDANCE_CALIBRATION_CMD, SHORT_IMPEDANCE_CALIBRATION_CMD;
  logic [2:0] PARKED_TERMINATION_VALUE, NOMINAL_TERMINATION_VALUE, DQ_TERM_VALUE, TDQS_TERM_VALUE;
  logic [2:0] e;
  logic [4:0] c;
  logic [4:0] DRIVER_IMP_CODE, TERM_IMP_CODE;
  int         n_errors = 0, checks_done = 0, cyc = 0, n;

  zqc_top zqc_top_inst (.*);
  zqc_ctrl_model zqc_ctrl_model_inst (.*);

  initial begin
    CLOCK = 1'b0;
    forever #50 CLOCK = ~CLOCK;
  end

  function automatic int exp_len(logic f);
    return (f ? INIT_CAL_CYCLES : OPER_CAL_CYCLES) + 1;
  endfunction

  function automatic logic [2:0] exp_term(logic [2:0] p, logic [2:0] nv, logic o, logic s);
    return (!s && (nv == NOM_DIS || o)) ? p : RTT_OFF;
  endfunction

  task automatic chk(string nm, logic [11:0] ex, logic [11:0] sn);
    checks_done++;
    if (ex !== sn) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, sn);
    end
  endtask

  task automatic send_cmd(logic lng, logic ck);
    KIND_LONG <= lng;
    CKE_EN <= ck;
    SEND <= 1'b1;
    @(posedge CLOCK);
    SEND <= 1'b0;
  endtask

  // counts busy cycles; optionally retries mid-run with a random comparator
  // the first wake that reads busy low still reads the done pulse
  task automatic cal(logic first_cal, logic again);
    n = 0;
    for (int i = 0; i < 60 && CAL_BUSY !== 1'b1; i++) @(posedge CLOCK);
    while (CAL_BUSY === 1'b1 && n < 2000) begin
      n++;
      SEND <= again && n == 100;
      if (again) CAL_CMP_HIGH <= 1'($urandom);
      if (n == 5) chk("term in cal", 0, DQ_TERM_VALUE);
      @(posedge CLOCK);
    end
    chk("busy cycles", 12'(exp_len(first_cal)), 12'(n));
    chk("done pulse", 1, CAL_DONE_PULSE);
    chk("first done", 1, CAL_FIRST_DONE);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      finish_test();
    end
  end

  initial begin
    void'($urandom(32'h3a4f));
    {RST, CKE_EN, TDQS_ENABLE} = 3'h7;
    {SEND, KIND_LONG, ODT, CAL_CMP_HIGH, SELF_REFRESH} = 5'h00;
    PARKED_TERMINATION_VALUE = 3'h5;
    NOMINAL_TERMINATION_VALUE = 3'h1;
    repeat (4) @(posedge CLOCK);
    RST <= 1'b0;
    repeat (4) @(posedge CLOCK);
    // short command, then long with clock enable low: both must leave no trace
    for (int k = 0; k < 2; k++) begin
      send_cmd(k == 1, k == 0);
      repeat (30) @(posedge CLOCK);
      chk("busy idle", 0, CAL_BUSY);
      chk("first idle", 0, CAL_FIRST_DONE);
      chk("code idle", CODE_RST, DRIVER_IMP_CODE);
    end
    $display("test ignored commands done");
    ODT <= 1'b1;
    send_cmd(1'b1, 1'b1);
    cal(1'b1, 1'b0);
    chk("code up", CODE_MAX, DRIVER_IMP_CODE);
    chk("term code up", CODE_MAX, TERM_IMP_CODE);
    CAL_CMP_HIGH <= 1'b1;
    send_cmd(1'b1, 1'b1);
    cal(1'b0, 1'b0);
    chk("code down", 1, DRIVER_IMP_CODE <= 5'h01);
    chk("term code down", 1, TERM_IMP_CODE <= 5'h01);
    $display("test calibrations done");
    c = DRIVER_IMP_CODE;
    SELF_REFRESH <= 1'b1;
    repeat (6) @(posedge CLOCK);
    chk("sr term", RTT_OFF, DQ_TERM_VALUE);
    SELF_REFRESH <= 1'b0;
    repeat (30) @(posedge CLOCK);
    chk("sr exit busy", 0, CAL_BUSY);
    chk("sr exit code", c, DRIVER_IMP_CODE);
    send_cmd(1'b1, 1'b1);
    cal(1'b0, 1'b1);
    $display("test self-refresh done");
    for (int i = 0; i < 40; i++) begin
      PARKED_TERMINATION_VALUE <= 3'($urandom);
      NOMINAL_TERMINATION_VALUE <= (i % 4 == 0) ? NOM_DIS : 3'($urandom);
      ODT <= 1'($urandom);
      TDQS_ENABLE <= 1'($urandom);
      SELF_REFRESH <= (i % 5 == 0);
      repeat (5) @(posedge CLOCK);
      e = exp_term(PARKED_TERMINATION_VALUE, NOMINAL_TERMINATION_VALUE, ODT, SELF_REFRESH);
      chk("dq term", e, DQ_TERM_VALUE);
      chk("tdqs term", TDQS_ENABLE ? e : RTT_OFF, TDQS_TERM_VALUE);
    end
    $display("test termination done");
    finish_test();
  end
endmodule
